/* gfs_top.sv */
// General-pin function select for pins zero and nine
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Pin zero field in bits 2:0 picks input for 000 (default) and output for 001.
// - Pin zero codes 010..111 route port 2/3 attention button, power fault, interlock engage.
// - Fields load from the configuration EEPROM and clear on fundamental reset.
// - A high port-2 strap at reset release dedicates the pin to slot power-on.
// - The second select register is 16 bits at offset BEh, resets to 0000h, covers pins 5-9.
// - Bit 15 of the second select register is read-only and reads zero.
// - Pin nine field in bits 14:12 picks input for 000 (default) and output for 001.
module gfs_top
  import gfs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Configuration access
  input wire logic cfg_wr_en_in,
  input wire logic cfg_rd_en_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [15:0] cfg_wdata_in,
  output logic [15:0] cfg_rdata_out,
  // EEPROM load path
  input wire logic eeprom_wr_en_in,
  input wire logic [7:0] eeprom_addr_in,
  input wire logic [15:0] eeprom_data_in,
  // Strap and general data
  input wire logic port2_hotplug_strap_in,
  input wire logic [1:0] gp_data_in,
  output logic [1:0] gp_level_out,
  // Pin zero
  input wire logic pin0_in,
  output logic pin0_out,
  output logic pin0_oe_out,
  // Pin nine
  input wire logic pin9_in,
  output logic pin9_out,
  output logic pin9_oe_out,
  // Hot-plug sources
  input wire logic slot_power_on_output_in,
  input wire logic port1_interlock_control_in,
  input wire logic port2_interlock_control_in,
  input wire logic port1_attention_indicator_in,
  input wire logic port2_attention_indicator_in,
  input wire logic port1_power_indicator_in,
  input wire logic port2_power_indicator_in,
  // Hot-plug senses
  output logic port2_attention_button_out,
  output logic port3_attention_button_out,
  output logic port2_power_fault_out,
  output logic port3_power_fault_out,
  output logic port2_interlock_engage_out,
  output logic port3_interlock_engage_out,
  // Strap status
  output logic strap_active_out
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Select registers
  // ----------------------------------------
  logic [15:0] select_a_reg;
  logic [15:0] select_b_reg;
  logic wr_a;
  logic wr_b;
  logic [15:0] wr_data;

  // Software write wins over a same-cycle EEPROM load
  assign wr_data = cfg_wr_en_in ? cfg_wdata_in : eeprom_data_in;
  assign wr_a = (cfg_wr_en_in && cfg_addr_in == GFS_OFF_SELECT_A) ||
                (!cfg_wr_en_in && eeprom_wr_en_in && eeprom_addr_in == GFS_OFF_SELECT_A);
  assign wr_b = (cfg_wr_en_in && cfg_addr_in == GFS_OFF_SELECT_B) ||
                (!cfg_wr_en_in && eeprom_wr_en_in && eeprom_addr_in == GFS_OFF_SELECT_B);

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      select_a_reg <= GFS_SELECT_A_RESET;
      select_b_reg <= GFS_SELECT_B_RESET;
    end else begin
      if (wr_a) begin
        select_a_reg <= wr_data;
      end
      if (wr_b) begin
        select_b_reg <= wr_data & GFS_SELECT_B_WMASK;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_out <= 16'h0000;
    end else if (cfg_rd_en_in) begin
      case (cfg_addr_in)
        GFS_OFF_SELECT_A: begin
          cfg_rdata_out <= select_a_reg;
        end
        GFS_OFF_SELECT_B: begin
          cfg_rdata_out <= select_b_reg & GFS_SELECT_B_WMASK;
        end
        default: begin
          cfg_rdata_out <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Sampled once, on the first edge after reset release
  logic strap_done_reg;
  logic strap_reg;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg <= port2_hotplug_strap_in;
    end
  end

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  logic [2:0] pin0_func;
  logic [2:0] pin9_func;
  logic p0_out;
  logic p0_oe;
  logic p9_out;
  logic p9_oe;
  logic [5:0] p0_sense;
  logic [5:0] p9_src;

  // While strapped the field is ignored and read as plain input
  assign pin0_func = strap_reg ? GFS_CODE_INPUT :
                     select_a_reg[GFS_PIN0_LSB +: GFS_FIELD_W];
  assign pin9_func = select_b_reg[GFS_PIN9_LSB +: GFS_FIELD_W];
  assign p9_src = {port2_power_indicator_in, port1_power_indicator_in,
                   port2_attention_indicator_in, port1_attention_indicator_in,
                   port2_interlock_control_in, port1_interlock_control_in};

  gfs_pin_cell #(
    .ALT_DRIVES(GFS_PIN0_ALT_DRIVES)
  ) u_pin0 (
    .func_in(pin0_func),
    .gp_data_in(gp_data_in[0]),
    .alt_src_in(6'h00),
    .pin_in(pin0_in),
    .pin_out(p0_out),
    .pin_oe_out(p0_oe),
    .alt_sense_out(p0_sense)
  );

  gfs_pin_cell #(
    .ALT_DRIVES(GFS_PIN9_ALT_DRIVES)
  ) u_pin9 (
    .func_in(pin9_func),
    .gp_data_in(gp_data_in[1]),
    .alt_src_in(p9_src),
    .pin_in(pin9_in),
    .pin_out(p9_out),
    .pin_oe_out(p9_oe),
    .alt_sense_out()
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin0_out <= 1'b0;
      pin0_oe_out <= 1'b0;
      pin9_out <= 1'b0;
      pin9_oe_out <= 1'b0;
      gp_level_out <= 2'h0;
      strap_active_out <= 1'b0;
    end else begin
      pin0_out <= strap_reg ? slot_power_on_output_in : p0_out;
      pin0_oe_out <= strap_reg | p0_oe;
      pin9_out <= p9_out;
      pin9_oe_out <= p9_oe;
      gp_level_out <= {pin9_in, pin0_in & !strap_reg};
      strap_active_out <= strap_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      port2_attention_button_out <= 1'b0;
      port3_attention_button_out <= 1'b0;
      port2_power_fault_out <= 1'b0;
      port3_power_fault_out <= 1'b0;
      port2_interlock_engage_out <= 1'b0;
      port3_interlock_engage_out <= 1'b0;
    end else begin
      port2_attention_button_out <= p0_sense[0];
      port3_attention_button_out <= p0_sense[1];
      port2_power_fault_out <= p0_sense[2];
      port3_power_fault_out <= p0_sense[3];
      port2_interlock_engage_out <= p0_sense[4];
      port3_interlock_engage_out <= p0_sense[5];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reserved_bit_zero;
    @(posedge mclk_in) disable iff (!rst_n)
    (cfg_rd_en_in && cfg_addr_in == GFS_OFF_SELECT_B) |=> !cfg_rdata_out[GFS_RESERVED_BIT_BIT];
  endproperty
  a_reserved_bit_zero: assert property (p_reserved_bit_zero) else $error("reserved bit read one");

  property p_pin0_input;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin0_func == GFS_CODE_INPUT && !strap_reg) |=> !pin0_oe_out;
  endproperty
  a_pin0_input: assert property (p_pin0_input) else $error("pin zero driven as input");

  property p_pin0_output;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin0_func == GFS_CODE_OUTPUT) |=> (pin0_oe_out && pin0_out == $past(gp_data_in[0]));
  endproperty
  a_pin0_output: assert property (p_pin0_output) else $error("pin zero output wrong");

  property p_pin0_button;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin0_func == 3'h2) |=> (port2_attention_button_out == $past(pin0_in)) && !pin0_oe_out;
  endproperty
  a_pin0_button: assert property (p_pin0_button) else $error("button route wrong");

  property p_pin0_engage;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin0_func != 3'h7) |=> !port3_interlock_engage_out;
  endproperty
  a_pin0_engage: assert property (p_pin0_engage) else $error("engage leaks");

  property p_strap;
    @(posedge mclk_in) disable iff (!rst_n)
    strap_reg |=> pin0_oe_out && pin0_out == $past(slot_power_on_output_in) && strap_active_out;
  endproperty
  a_strap: assert property (p_strap) else $error("strap override wrong");

  property p_write_b;
    @(posedge mclk_in) disable iff (!rst_n)
    (cfg_wr_en_in && cfg_addr_in == GFS_OFF_SELECT_B) |=>
      select_b_reg == ($past(cfg_wdata_in) & GFS_SELECT_B_WMASK);
  endproperty
  a_write_b: assert property (p_write_b) else $error("select b write lost");

  property p_reset_clear;
    @(posedge mclk_in) $rose(rst_n) |-> select_a_reg == 16'h0000 && select_b_reg == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared");

  property p_pin9_ctl;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin9_func == 3'h3) |=> pin9_oe_out && pin9_out == $past(port2_interlock_control_in);
  endproperty
  a_pin9_ctl: assert property (p_pin9_ctl) else $error("pin nine route wrong");

  property p_pin9_input;
    @(posedge mclk_in) disable iff (!rst_n)
    (pin9_func == GFS_CODE_INPUT) |=> !pin9_oe_out;
  endproperty
  a_pin9_input: assert property (p_pin9_input) else $error("pin nine driven as input");
endmodule
`default_nettype wire

/* gfs_pkg.sv */
// Constants for the general-pin function select block
package gfs_pkg;
  // ----------------------------------------
  // Configuration offsets
  // ----------------------------------------
  localparam logic [7:0] GFS_OFF_SELECT_A = 8'hbc;
  localparam logic [7:0] GFS_OFF_SELECT_B = 8'hbe;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int GFS_FIELD_W = 3;
  localparam int GFS_PIN0_LSB = 0;
  localparam int GFS_PIN9_LSB = 12;
  localparam int GFS_RESERVED_BIT_BIT = 15;
  localparam logic [15:0] GFS_SELECT_A_RESET = 16'h0000;
  localparam logic [15:0] GFS_SELECT_B_RESET = 16'h0000;
  localparam logic [15:0] GFS_SELECT_B_WMASK = 16'h7fff;
  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [2:0] GFS_CODE_INPUT = 3'h0;
  localparam logic [2:0] GFS_CODE_OUTPUT = 3'h1;
  localparam logic [2:0] GFS_CODE_ALT_FIRST = 3'h2;
  localparam int GFS_ALT_N = 6;
  // Alternate roles that drive the pin, one bit per code 2..7
  localparam logic [5:0] GFS_PIN0_ALT_DRIVES = 6'h00;
  localparam logic [5:0] GFS_PIN9_ALT_DRIVES = 6'h3f;
endpackage

/* gfs_pin_cell.sv */
// One general pin: function decode and routing
`timescale 1ns/1ps
`default_nettype none
module gfs_pin_cell
  import gfs_pkg::*;
#(
  parameter logic [5:0] ALT_DRIVES = 6'h00
) (
  // Selection
  input wire logic [2:0] func_in,
  input wire logic gp_data_in,
  input wire logic [5:0] alt_src_in,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  // Routes to hot-plug logic
  output logic [5:0] alt_sense_out
);
  always_comb begin
    pin_out = 1'b0;
    pin_oe_out = 1'b0;
    case (func_in)
      GFS_CODE_INPUT: begin
        pin_oe_out = 1'b0;
      end
      GFS_CODE_OUTPUT: begin
        pin_out = gp_data_in;
        pin_oe_out = 1'b1;
      end
      default: begin
        // Direction follows the role of the chosen hot-plug signal
        pin_oe_out = ALT_DRIVES[func_in - GFS_CODE_ALT_FIRST];
        pin_out = pin_oe_out & alt_src_in[func_in - GFS_CODE_ALT_FIRST];
      end
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < GFS_ALT_N; k++) begin : g_route
      assign alt_sense_out[k] = !ALT_DRIVES[k] &&
                                (func_in == 3'(k + 2)) && pin_in;
    end
  endgenerate
endmodule
`default_nettype wire

/* gpio_function_select_tb.sv */
// Self-checking testbench for the general-pin function select block
`timescale 1ns/1ps
`default_nettype none
module gpio_function_select_tb;
  import gfs_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  typedef struct {
    logic [2:0] code;
    logic p0in;
    logic p9in;
    logic [1:0] gp;
    logic [5:0] src;
    logic [5:0] sense;
    logic oe0;
    logic out0;
    logic oe9;
    logic out9;
    logic [1:0] lvl;
  } gfs_tb_row_t;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cfg_wr_en_in = 1'b0;
  logic cfg_rd_en_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [15:0] cfg_wdata_in = 16'h0000;
  logic eeprom_wr_en_in = 1'b0;
  logic [7:0] eeprom_addr_in = 8'h00;
  logic [15:0] eeprom_data_in = 16'h0000;
  logic strap = 1'b0;
  logic [1:0] gp_data_in = 2'h0;
  logic pin0_in = 1'b0;
  logic pin9_in = 1'b0;
  logic slot_pwr = 1'b0;
  logic [5:0] src = 6'h00;
  logic [15:0] cfg_rdata_out;
  logic [1:0] gp_level_out;
  logic pin0_out, pin0_oe_out, pin9_out, pin9_oe_out, strap_active_out;
  wire logic [5:0] sense;
  logic [15:0] rd;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  gfs_tb_row_t rows[$];
  gfs_tb_row_t r;

  gfs_top dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .cfg_wr_en_in(cfg_wr_en_in), .cfg_rd_en_in(cfg_rd_en_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .eeprom_wr_en_in(eeprom_wr_en_in), .eeprom_addr_in(eeprom_addr_in),
    .eeprom_data_in(eeprom_data_in), .port2_hotplug_strap_in(strap),
    .gp_data_in(gp_data_in), .gp_level_out(gp_level_out),
    .pin0_in(pin0_in), .pin0_out(pin0_out), .pin0_oe_out(pin0_oe_out),
    .pin9_in(pin9_in), .pin9_out(pin9_out), .pin9_oe_out(pin9_oe_out),
    .slot_power_on_output_in(slot_pwr),
    .port1_interlock_control_in(src[0]), .port2_interlock_control_in(src[1]),
    .port1_attention_indicator_in(src[2]), .port2_attention_indicator_in(src[3]),
    .port1_power_indicator_in(src[4]), .port2_power_indicator_in(src[5]),
    .port2_attention_button_out(sense[0]), .port3_attention_button_out(sense[1]),
    .port2_power_fault_out(sense[2]), .port3_power_fault_out(sense[3]),
    .port2_interlock_engage_out(sense[4]), .port3_interlock_engage_out(sense[5]),
    .strap_active_out(strap_active_out)
  );

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("unexpected cycle count: expected below 5000, seen %0d", cycles);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    cfg_wr_en_in = 1'b1;
    cfg_addr_in = a;
    cfg_wdata_in = d;
    @(negedge mclk_in);
    cfg_wr_en_in = 1'b0;
  endtask

  // Read data stands until the next read, so one spare cycle is harmless
  task automatic cfg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk_in);
    cfg_rd_en_in = 1'b1;
    cfg_addr_in = a;
    @(negedge mclk_in);
    cfg_rd_en_in = 1'b0;
    @(negedge mclk_in);
    d = cfg_rdata_out;
  endtask

  task automatic do_reset(input logic s);
    @(negedge mclk_in);
    resetn_in = 1'b0;
    strap = s;
    repeat (16) @(negedge mclk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge mclk_in);
  endtask

  task automatic add_row(input logic [2:0] c, input logic a, input logic b, input logic [1:0] g,
                         input logic [5:0] s, input logic [5:0] e, input logic [5:0] o,
                         input logic [1:0] l);
    rows.push_back('{c, a, b, g, s, e, o[3], o[2], o[1], o[0], l});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(1'b0);
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b reset", 16'h0000, rd);
    chk("pin outputs after reset", 16'h0000, {pin0_oe_out, pin9_oe_out, sense, strap_active_out});
    add_row(3'h0, 1'b1, 1'b0, 2'h3, 6'h3f, 6'h00, 6'h0, 2'h1);
    add_row(3'h0, 1'b0, 1'b1, 2'h0, 6'h00, 6'h00, 6'h0, 2'h2);
    add_row(3'h1, 1'b1, 1'b0, 2'h1, 6'h3f, 6'h00, 6'he, 2'h1);
    add_row(3'h1, 1'b0, 1'b1, 2'h2, 6'h00, 6'h00, 6'hb, 2'h2);
    for (int c = 2; c < 8; c++) begin
      add_row(3'(c), 1'b1, 1'b0, 2'h0, 6'h01 << (c - 2), 6'h01 << (c - 2), 6'h3, 2'h0);
      add_row(3'(c), 1'b0, 1'b1, 2'h3, ~(6'h01 << (c - 2)), 6'h00, 6'h2, 2'h0);
    end
    foreach (rows[i]) begin
      r = rows[i];
      cfg_wr(GFS_OFF_SELECT_A, {13'h0000, r.code});
      cfg_wr(GFS_OFF_SELECT_B, {1'b0, r.code, 12'h000});
      pin0_in = r.p0in;
      pin9_in = r.p9in;
      gp_data_in = r.gp;
      src = r.src;
      repeat (2) @(negedge mclk_in);
      chk("pin zero senses", {10'h000, r.sense}, {10'h000, sense});
      chk("pin zero enable", {15'h0000, r.oe0}, {15'h0000, pin0_oe_out});
      if (r.oe0) chk("pin zero out", {15'h0000, r.out0}, {15'h0000, pin0_out});
      chk("pin nine enable", {15'h0000, r.oe9}, {15'h0000, pin9_oe_out});
      if (r.oe9) chk("pin nine out", {15'h0000, r.out9}, {15'h0000, pin9_out});
      if (r.code < 3'h2) chk("pin levels", {14'h0000, r.lvl}, {14'h0000, gp_level_out});
    end
    // Reserved bit, unmapped place, loader and write collision
    cfg_wr(GFS_OFF_SELECT_B, 16'hffff);
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b all ones", 16'h7fff, rd);
    cfg_wr(8'hc0, 16'h1234);
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b after stray write", 16'h7fff, rd);
    cfg_rd(8'hc0, rd);
    chk("unmapped read", 16'h0000, rd);
    @(negedge mclk_in);
    eeprom_wr_en_in = 1'b1;
    eeprom_addr_in = GFS_OFF_SELECT_B;
    eeprom_data_in = 16'hd123;
    @(negedge mclk_in);
    eeprom_wr_en_in = 1'b0;
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b loaded", 16'h5123, rd);
    @(negedge mclk_in);
    eeprom_wr_en_in = 1'b1;
    eeprom_data_in = 16'h2000;
    cfg_wr(GFS_OFF_SELECT_B, 16'h1000);
    eeprom_wr_en_in = 1'b0;
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b collision", 16'h1000, rd);
    // Mid-run reset with the strap high
    cfg_wr(GFS_OFF_SELECT_A, 16'h0002);
    pin0_in = 1'b1;
    slot_pwr = 1'b1;
    do_reset(1'b1);
    cfg_rd(GFS_OFF_SELECT_B, rd);
    chk("select b after reset", 16'h0000, rd);
    cfg_rd(GFS_OFF_SELECT_A, rd);
    chk("select a after reset", 16'h0000, rd);
    chk("strap state", 16'h0007, {13'h0000, strap_active_out, pin0_oe_out, pin0_out});
    cfg_wr(GFS_OFF_SELECT_A, 16'h0002);
    slot_pwr = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk("strapped pin zero", 16'h0006, {13'h0000, strap_active_out, pin0_oe_out, pin0_out});
    chk("strapped senses", 16'h0000, {9'h000, sense, gp_level_out[0]});
    do_reset(1'b0);
    chk("strap released", 16'h0000, {15'h0000, strap_active_out});
    test_done();
  end
endmodule
`default_nettype wire
